// ---- ast_pkg.sv ----
// How it works
// - independent transmitter and receiver, one rate generator
// - select bit picks bus clock or four times
// - length bit picks 8/9; ninth from field
// - ninth received bit, or copy of bit 7
// - preamble of ones precedes first data word
// - start zero first, stop one last
// - buffer transfer sets empty flag; irq when enabled
// - idle line high when nothing to send, low when inverted
// - module disable releases pins to port control
// - send break repeats all-zero break characters
// - after break, finish it, then send one
// - break is 10/11 or 11/12 zero bits
// - break sets error, full, break; clears data
// - idle character all ones; preamble is one
// - transmitter disable finishes character then idles
// - disable then re-enable queues one idle character
// - invert bit inverts every transmitted level
// - complete character loads buffer, sets full flag
// - buffer writes feed transmit, reads return receive
// - sixteen rate ticks per bit, one mid-bit sample, resync on start
// - missing stop one sets framing error
package ast_pkg;
   localparam int AST_OVERSAMPLE = 16;
   localparam int AST_MID_SAMPLE = 8;
   localparam int AST_HALF_BIT = 7;
   localparam int AST_FRAME_BITS_8 = 10;
   localparam int AST_BREAK_EXTRA = 1;
   localparam logic [15:0] AST_DIV_RESET = 16'h001A;

   typedef struct packed
   {
      logic module_enable;
      logic transmitter_enable;
      logic receiver_enable;
      logic char_ninth;
      logic send_break;
      logic transmit_invert;
      logic extended_break_select;
      logic clock_source_select;
      logic transmit_irq_enable;
      logic receive_irq_enable;
   } ast_ctrl_t;

   typedef struct packed
   {
      logic transmit_empty_flag;
      logic transmit_complete;
      logic receiver_full_flag;
      logic framing_error_flag;
      logic break_flag;
      logic noise_flag;
      logic overrun_flag;
      logic reception_in_progress_flag;
   } ast_status_t;

   typedef enum logic [1:0]
   {
      AST_TX_IDLE = 2'b00,
      AST_TX_SHIFT = 2'b01
   } ast_tx_state_t;

   typedef enum logic [1:0]
   {
      AST_RX_HUNT = 2'b00,
      AST_RX_START = 2'b01,
      AST_RX_DATA = 2'b10
   } ast_rx_state_t;
endpackage : ast_pkg

// ---- ast_remote.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// remote serial device
// ****
module ast_remote
(
   input wire logic mclk_i,
   input wire logic txd_i,
   output logic rxd_o
);
   initial rxd_o = 1'b1;
   // frame goes out lsb first, bt clocks a bit, line back to idle high
   task automatic send(input logic [11:0] f, input int n, input int bt);
      for (int i = 0; i < n; i++)
      begin
         rxd_o <= f[i];
         repeat (bt) @(posedge mclk_i);
      end
      rxd_o <= 1'b1;
   endtask : send
   // start level is the inverse of idle; samples taken mid bit
   task automatic recv(input logic inv, input int n, input int bt, output logic [11:0] v);
      v = 12'h000;
      @(posedge mclk_i iff txd_i === inv);
      repeat (bt / 2) @(posedge mclk_i);
      for (int i = 0; i < n; i++)
      begin
         v[i] = txd_i ^ inv;
         repeat (bt) @(posedge mclk_i);
      end
   endtask : recv
endmodule : ast_remote
`default_nettype wire

// ---- ast_uart.sv ----
`timescale 1ns/10ps
`default_nettype none
module ast_uart
   import ast_pkg::*;
#(
   parameter int DIV_W = 16
)
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire ast_ctrl_t ctrl_i,
   input wire logic [DIV_W-1:0] bit_rate_control_i,
   input wire logic [7:0] wr_data_i,
   input wire logic tx_ninth_bit_i,
   input wire logic wr_stb_i,
   input wire logic rd_stb_i,
   input wire logic status_rd_i,
   output logic [7:0] rd_data_o,
   output logic rx_ninth_bit_o,
   output ast_status_t status_o,
   output logic tx_irq_o,
   output logic rx_irq_o,
   input wire logic rxd_i,
   output logic txd_o,
   output logic txd_oe_o,
   output logic pins_owned_o
);
   // ****************************************
   // rate generator
   // ****************************************
   logic [1:0] quarter;
   logic [DIV_W-1:0] div_cnt;
   logic mod_tick;
   logic rt_tick;
   // bus clock mode ticks every fourth mclk, x4 mode every mclk
   assign mod_tick = ctrl_i.clock_source_select ? (quarter == 2'h3) : 1'b1;
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         quarter <= 2'h0;
      else
         quarter <= quarter + 2'h1;
   end
   // one shared divider feeds both directions
   always_ff @(posedge mclk_i)
   begin
      if (rst_i || !ctrl_i.module_enable)
         div_cnt <= '0;
      else if (mod_tick)
         div_cnt <= (div_cnt + 1'b1 >= bit_rate_control_i) ? '0 : div_cnt + 1'b1;
   end
   assign rt_tick = mod_tick && (div_cnt + 1'b1 >= bit_rate_control_i);

   // ****************************************
   // transmitter
   // ****************************************
   ast_tx_state_t tx_state;
   // one spare stop position keeps the line low between back-to-back long breaks
   logic [12:0] tx_shift;
   logic [3:0] tx_bits;
   logic [3:0] tx_rt;
   logic [7:0] tx_buf;
   logic tx_buf_ninth;
   logic preamble_due;
   logic idle_queued;
   logic te_prev;
   logic brk_tail;
   logic tx_line;
   logic [3:0] frame_len;
   assign frame_len = ctrl_i.char_ninth ? 4'(AST_FRAME_BITS_8 + 1) : 4'(AST_FRAME_BITS_8);

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         te_prev <= 1'b0;
      else
         te_prev <= ctrl_i.transmitter_enable;
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i || !ctrl_i.module_enable)
      begin
         tx_state <= AST_TX_IDLE;
         tx_shift <= '1;
         tx_bits <= 4'h0;
         tx_rt <= 4'h0;
         status_o.transmit_empty_flag <= 1'b1;
         status_o.transmit_complete <= 1'b1;
         preamble_due <= 1'b1;
         idle_queued <= 1'b0;
         brk_tail <= 1'b0;
         tx_buf <= 8'h00;
         tx_buf_ninth <= 1'b0;
      end
      else
      begin
         // software write clears empty; buffer stands write-only to shifter
         if (wr_stb_i)
         begin
            tx_buf <= wr_data_i;
            tx_buf_ninth <= tx_ninth_bit_i;
            status_o.transmit_empty_flag <= 1'b0;
            status_o.transmit_complete <= 1'b0;
         end
         if (!te_prev && ctrl_i.transmitter_enable && tx_state == AST_TX_SHIFT)
            idle_queued <= 1'b1;
         if (!ctrl_i.transmitter_enable && tx_state == AST_TX_IDLE)
            preamble_due <= 1'b1;
         if (ctrl_i.send_break)
            brk_tail <= 1'b1;
         unique case (tx_state)
            AST_TX_IDLE:
            begin
               tx_shift <= '1;
               if (ctrl_i.transmitter_enable)
               begin
                  tx_rt <= 4'h0;
                  tx_state <= AST_TX_SHIFT;
                  if (preamble_due || idle_queued)
                  begin
                     // preamble is an idle character of ones
                     tx_shift <= '1;
                     tx_bits <= frame_len;
                     preamble_due <= 1'b0;
                     idle_queued <= 1'b0;
                  end
                  else if (ctrl_i.send_break)
                  begin
                     // extended select adds one zero bit
                     tx_shift <= '0;
                     tx_bits <= frame_len
                        + (ctrl_i.extended_break_select ? 4'(AST_BREAK_EXTRA) : 4'h0);
                  end
                  else if (brk_tail)
                  begin
                     tx_shift <= '1;
                     tx_bits <= 4'h1;
                     brk_tail <= 1'b0;
                  end
                  else if (!status_o.transmit_empty_flag && !wr_stb_i)
                  begin
                     // stop high, start low at lsb, data lsb first
                     tx_shift <= ctrl_i.char_ninth ? {3'b111, tx_buf_ninth, tx_buf, 1'b0}
                                                  : {4'b1111, tx_buf, 1'b0};
                     tx_bits <= frame_len;
                     status_o.transmit_empty_flag <= 1'b1;
                  end
                  else
                  begin
                     tx_state <= AST_TX_IDLE;
                     status_o.transmit_complete <= 1'b1;
                  end
               end
            end
            AST_TX_SHIFT:
            begin
               if (rt_tick)
               begin
                  tx_rt <= tx_rt + 4'h1;
                  if (tx_rt == 4'(AST_OVERSAMPLE - 1))
                  begin
                     tx_shift <= {1'b1, tx_shift[12:1]};
                     tx_bits <= tx_bits - 4'h1;
                     if (tx_bits == 4'h1)
                        tx_state <= AST_TX_IDLE;
                  end
               end
            end
            default:
               tx_state <= AST_TX_IDLE;
         endcase
      end
   end
   // the reload cycle between characters keeps the last level, so breaks run unbroken
   assign tx_line = tx_shift[0];
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         txd_o <= 1'b1;
      else
         txd_o <= tx_line ^ ctrl_i.transmit_invert;
   end
   // disabled module hands both pins back to the port
   assign pins_owned_o = ctrl_i.module_enable;
   assign txd_oe_o = ctrl_i.module_enable && ctrl_i.transmitter_enable;
   assign tx_irq_o = status_o.transmit_empty_flag && ctrl_i.transmit_irq_enable;

   // ****************************************
   // receiver
   // ****************************************
   logic rx_meta;
   logic rx_sync;
   ast_rx_state_t rx_state;
   logic [3:0] rx_rt;
   logic [3:0] rx_bits;
   logic [9:0] rx_shift;
   logic rx_zero_all;
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
      end
      else
      begin
         rx_meta <= rxd_i;
         rx_sync <= rx_meta;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i || !ctrl_i.module_enable)
      begin
         rx_state <= AST_RX_HUNT;
         rx_rt <= 4'h0;
         rx_bits <= 4'h0;
         rx_shift <= '0;
         rx_zero_all <= 1'b0;
         rd_data_o <= 8'h00;
         rx_ninth_bit_o <= 1'b0;
         status_o.receiver_full_flag <= 1'b0;
         status_o.framing_error_flag <= 1'b0;
         status_o.break_flag <= 1'b0;
         status_o.noise_flag <= 1'b0;
         status_o.overrun_flag <= 1'b0;
         status_o.reception_in_progress_flag <= 1'b0;
      end
      else
      begin
         // read together with status read in one cycle clears flags; a same-cycle set below wins
         if (rd_stb_i && status_rd_i)
         begin
            status_o.receiver_full_flag <= 1'b0;
            status_o.framing_error_flag <= 1'b0;
            status_o.break_flag <= 1'b0;
            status_o.overrun_flag <= 1'b0;
         end
         unique case (rx_state)
            AST_RX_HUNT:
            begin
               if (ctrl_i.receiver_enable && !rx_sync)
               begin
                  rx_state <= AST_RX_START;
                  rx_rt <= 4'h0;
                  status_o.reception_in_progress_flag <= 1'b1;
               end
            end
            AST_RX_START:
            begin
               if (rt_tick)
               begin
                  rx_rt <= rx_rt + 4'h1;
                  if (rx_rt == 4'(AST_HALF_BIT))
                  begin
                     if (rx_sync)
                     begin
                        rx_state <= AST_RX_HUNT;
                        status_o.reception_in_progress_flag <= 1'b0;
                     end
                     else
                     begin
                        // restart the 16-step count centred on the start bit
                        rx_state <= AST_RX_DATA;
                        rx_rt <= 4'h0;
                        rx_bits <= frame_len - 4'h1;
                        rx_zero_all <= 1'b1;
                     end
                  end
               end
            end
            AST_RX_DATA:
            begin
               if (rt_tick)
               begin
                  rx_rt <= rx_rt + 4'h1;
                  if (rx_rt == 4'(AST_OVERSAMPLE - 1))
                  begin
                     rx_shift <= {rx_sync, rx_shift[9:1]};
                     rx_bits <= rx_bits - 4'h1;
                     if (rx_sync)
                        rx_zero_all <= 1'b0;
                     if (rx_bits == 4'h1)
                     begin
                        rx_state <= AST_RX_HUNT;
                        status_o.reception_in_progress_flag <= 1'b0;
                        status_o.receiver_full_flag <= 1'b1;
                        if (status_o.receiver_full_flag && !(rd_stb_i && status_rd_i))
                           status_o.overrun_flag <= 1'b1;
                        status_o.framing_error_flag <= !rx_sync;
                        if (rx_zero_all && !rx_sync)
                        begin
                           // all zeros through stop: break
                           status_o.break_flag <= 1'b1;
                           rd_data_o <= 8'h00;
                           rx_ninth_bit_o <= 1'b0;
                        end
                        else if (ctrl_i.char_ninth)
                        begin
                           rd_data_o <= rx_shift[8:1];
                           rx_ninth_bit_o <= rx_shift[9];
                        end
                        else
                        begin
                           rd_data_o <= rx_shift[9:2];
                           rx_ninth_bit_o <= rx_shift[9];
                        end
                     end
                  end
               end
            end
            default:
               rx_state <= AST_RX_HUNT;
         endcase
      end
   end
   assign rx_irq_o = status_o.receiver_full_flag && ctrl_i.receive_irq_enable;
endmodule : ast_uart
`default_nettype wire

// ---- ast_uart_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// port checks
// ****
module ast_uart_chk
   import ast_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire ast_ctrl_t ctrl_i,
   input wire logic wr_stb_i,
   input wire logic [7:0] rd_data_o,
   input wire logic rx_ninth_bit_o,
   input wire ast_status_t status_o,
   input wire logic tx_irq_o,
   input wire logic rx_irq_o,
   input wire logic txd_o,
   input wire logic txd_oe_o,
   input wire logic pins_owned_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence s_wr;
      wr_stb_i && ctrl_i.module_enable;
   endsequence
   sequence s_off;
      !ctrl_i.module_enable [*3] ##0 $stable(ctrl_i.transmit_invert);
   endsequence
   AST_OE: assert property (txd_oe_o == (ctrl_i.module_enable && ctrl_i.transmitter_enable))
      else $error("output enable wrong");
   AST_PINS: assert property (pins_owned_o == ctrl_i.module_enable)
      else $error("pin ownership wrong");
   AST_TXIRQ: assert property (tx_irq_o == (status_o.transmit_empty_flag && ctrl_i.transmit_irq_enable))
      else $error("transmit irq wrong");
   AST_RXIRQ: assert property (rx_irq_o == (status_o.receiver_full_flag && ctrl_i.receive_irq_enable))
      else $error("receive irq wrong");
   AST_WR: assert property (s_wr |=> !status_o.transmit_empty_flag)
      else $error("empty flag not cleared by write");
   AST_IDLE: assert property (s_off |-> txd_o == !ctrl_i.transmit_invert)
      else $error("line not idle while disabled");
   AST_FE: assert property ($rose(status_o.framing_error_flag) |-> status_o.receiver_full_flag)
      else $error("framing error without full flag");
   AST_BRK: assert property ($rose(status_o.break_flag) |-> status_o.framing_error_flag &&
      rd_data_o == 8'h00 && !rx_ninth_bit_o)
      else $error("break effects wrong");
   AST_R8: assert property ($rose(status_o.receiver_full_flag) && !ctrl_i.char_ninth &&
      !status_o.break_flag |-> rx_ninth_bit_o == rd_data_o[7])
      else $error("ninth bit not copy of bit 7");
endmodule : ast_uart_chk
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// bench
// ****
module tb_top;
   import ast_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   ast_ctrl_t c = '0;
   logic [7:0] wd = 8'h00;
   logic t9 = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdat;
   logic r9;
   ast_status_t st;
   logic tirq;
   logic rirq;
   logic rxd;
   logic txd;
   logic oe;
   logic own;
   logic [11:0] v;
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;
   int t0;
   always #5 mclk_i = ~mclk_i;
   ast_uart DUT (.mclk_i(mclk_i), .rst_i(rst_i), .ctrl_i(c), .bit_rate_control_i(16'h0001),
      .wr_data_i(wd), .tx_ninth_bit_i(t9), .wr_stb_i(wr), .rd_stb_i(rd), .status_rd_i(rd),
      .rd_data_o(rdat), .rx_ninth_bit_o(r9), .status_o(st), .tx_irq_o(tirq), .rx_irq_o(rirq),
      .rxd_i(rxd), .txd_o(txd), .txd_oe_o(oe), .pins_owned_o(own));
   ast_remote u_rem (.mclk_i(mclk_i), .txd_i(txd), .rxd_o(rxd));
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : tick
   task automatic put(input logic [7:0] d, input logic n9);
      @(posedge mclk_i);
      wd <= d;
      t9 <= n9;
      wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask : put
   // status read and buffer read go together, as software clears the flags
   task automatic rxchk(input logic [11:0] f, input int n, input logic [15:0] e);
      u_rem.send(f, n, 16);
      tick(24);
      chk("rx", {rdat, r9, st.receiver_full_flag, st.framing_error_flag, st.break_flag, rirq}, e);
      @(posedge mclk_i);
      rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      tick(1);
      chk("clear", st.receiver_full_flag, 1'b0);
   endtask : rxchk
   task automatic final_report;
      $display("checks %0d errors %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   // whole run is near 3400 cycles
   always @(posedge mclk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails++;
         final_report;
      end
   end
   initial
   begin
      tick(2);
      @(posedge mclk_i) rst_i <= 1'b0;
      tick(1);
      chk("reset", {st.transmit_empty_flag, st.receiver_full_flag, txd}, 3'b101);
      put(8'h55, 1'b0);
      tick(1);
      chk("refused", st.transmit_empty_flag, 1'b1);
      @(posedge mclk_i) c.module_enable <= 1'b1;
      c.receiver_enable <= 1'b1;
      @(posedge mclk_i) c.transmitter_enable <= 1'b1;
      c.transmit_irq_enable <= 1'b1;
      t0 = cyc;
      put(8'hA5, 1'b0);
      u_rem.recv(1'b0, 10, 16, v);
      chk("tx8", v, 12'h34A);
      chk("preamble", cyc - t0 >= 328, 1'b1);
      tick(16);
      chk("empty", {st.transmit_empty_flag, tirq}, 2'b11);
      @(posedge mclk_i) c.char_ninth <= 1'b1;
      put(8'h3C, 1'b1);
      u_rem.recv(1'b0, 11, 16, v);
      chk("tx9", v, 12'h678);
      tick(16);
      @(posedge mclk_i) c.send_break <= 1'b1;
      tick(400);
      chk("break", txd, 1'b0);
      @(posedge mclk_i) c.send_break <= 1'b0;
      for (int i = 0; i < 200 && txd !== 1'b1; i++)
         tick(1);
      chk("break end", txd, 1'b1);
      tick(32);
      @(posedge mclk_i) c.transmit_invert <= 1'b1;
      c.char_ninth <= 1'b0;
      tick(2);
      chk("inv idle", txd, 1'b0);
      put(8'h81, 1'b0);
      u_rem.recv(1'b1, 10, 16, v);
      chk("inv tx", v, 12'h302);
      tick(16);
      @(posedge mclk_i) c.transmit_invert <= 1'b0;
      c.receive_irq_enable <= 1'b1;
      rxchk(12'h32C, 10, 16'h12D9);
      @(posedge mclk_i) c.char_ninth <= 1'b1;
      rxchk(12'h62A, 11, 16'h02B9);
      @(posedge mclk_i) c.char_ninth <= 1'b0;
      rxchk(12'h1E0, 10, 16'h1E1D);
      rxchk(12'h000, 10, 16'h000F);
      @(posedge mclk_i) c.module_enable <= 1'b0;
      tick(2);
      chk("release", {own, oe}, 2'b00);
      @(posedge mclk_i) c.module_enable <= 1'b1;
      c.clock_source_select <= 1'b1;
      tick(1);
      chk("own", {own, oe}, 2'b11);
      put(8'h5A, 1'b0);
      u_rem.recv(1'b0, 10, 64, v);
      chk("slow tx", v, 12'h2B4);
      final_report;
   end
endmodule : tb_top
bind ast_uart ast_uart_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .ctrl_i(ctrl_i),
   .wr_stb_i(wr_stb_i), .rd_data_o(rd_data_o), .rx_ninth_bit_o(rx_ninth_bit_o),
   .status_o(status_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o), .txd_o(txd_o),
   .txd_oe_o(txd_oe_o), .pins_owned_o(pins_owned_o));
`default_nettype wire
